// ==== serial_port_flags_and_interrupts_bench.sv ====
`timescale 1ns/10ps
module serial_port_flags_and_interrupts_bench;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] r;
  logic [15:0] vec;
  logic        pready, pslverr, rx_pin, tx_out, tx_oe, e, sclk;
  logic        rx_full_irq, tx_empty_irq, tx_done_irq, rx_error_irq, serial_irq;
  int          errors = 0;
  int          comparisons = 0;
  int          cyc = 0;

  always #25 sys_clk = ~sys_clk;

  sfi_station st (.sys_clk(sys_clk), .line(rx_pin));
  sfi_serial_unit DUT (.sys_clk(sys_clk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_rx_pin(rx_pin), .serial_tx_pin_out(tx_out),
    .serial_tx_pin_oe(tx_oe), .serial_clk_out(sclk), .rx_full_irq(rx_full_irq),
    .tx_empty_irq(tx_empty_irq), .tx_done_irq(tx_done_irq), .rx_error_irq(rx_error_irq),
    .serial_irq(serial_irq), .serial_irq_vector(vec));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one apb transfer; held until ready is seen at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r & m, x);
  endtask
  task results;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task t_irq;
    rd(sfi_pkg::ADDR_STAT, 32'hff, 32'h84);
    apb(1'b1, sfi_pkg::ADDR_CTRL, 32'h84);
    repeat (3) @(posedge sys_clk);
    chk({tx_empty_irq, tx_done_irq, serial_irq, vec}, {3'b111, 16'h0024});
    apb(1'b1, sfi_pkg::ADDR_CTRL, 32'h0);
    repeat (3) @(posedge sys_clk);
    chk({tx_empty_irq, tx_done_irq, serial_irq}, 32'h0);
    chk(sclk, 32'h1);
    rd(8'h18, 32'hffffffff, 32'h0);
    chk(e, 32'h1);
    $display("irq test ended");
  endtask

  task t_rx;
    apb(1'b1, sfi_pkg::ADDR_BAUD, 32'h0);
    apb(1'b1, sfi_pkg::ADDR_CTRL, 32'h50);
    st.send(8'ha5, 1'b1);
    for (int i = 0; i < 40 && rx_full_irq !== 1'b1; i++) @(posedge sys_clk);
    chk(rx_full_irq, 32'h1);
    rd(sfi_pkg::ADDR_RXB, 32'hff, 32'ha5);
    rd(sfi_pkg::ADDR_STAT, 32'h40, 32'h0);
    st.send(8'h3c, 1'b1);
    st.send(8'hc3, 1'b1);
    rd(sfi_pkg::ADDR_STAT, 32'h60, 32'h60);
    chk(rx_error_irq, 32'h1);
    rd(sfi_pkg::ADDR_RXB, 32'hff, 32'h3c);
    rd(sfi_pkg::ADDR_STAT, 32'h40, 32'h0);
    apb(1'b1, sfi_pkg::ADDR_STAT, 32'h0);
    st.send(8'h00, 1'b0);
    rd(sfi_pkg::ADDR_STAT, 32'h10, 32'h10);
    apb(1'b1, sfi_pkg::ADDR_STAT, 32'h0);
    repeat (200) @(posedge sys_clk);
    rd(sfi_pkg::ADDR_STAT, 32'h10, 32'h10);
    apb(1'b1, sfi_pkg::ADDR_CTRL, 32'h0);
    rd(sfi_pkg::ADDR_STAT, 32'h10, 32'h10);
    st.mark();
    apb(1'b1, sfi_pkg::ADDR_STAT, 32'h0);
    rd(sfi_pkg::ADDR_STAT, 32'h78, 32'h0);
    $display("rx test ended");
  endtask

  task t_tx;
    apb(1'b1, sfi_pkg::ADDR_PORT, 32'h3);
    apb(1'b1, sfi_pkg::ADDR_CTRL, 32'h20);
    apb(1'b1, sfi_pkg::ADDR_TXB, 32'h55);
    repeat (40) @(posedge sys_clk);
    rd(sfi_pkg::ADDR_STAT, 32'h84, 32'h80);
    repeat (200) @(posedge sys_clk);
    rd(sfi_pkg::ADDR_STAT, 32'h84, 32'h84);
    apb(1'b1, sfi_pkg::ADDR_CTRL, 32'h0);
    repeat (3) @(posedge sys_clk);
    chk({tx_oe, tx_out}, 32'h3);
    apb(1'b1, sfi_pkg::ADDR_PORT, 32'h2);
    repeat (3) @(posedge sys_clk);
    chk({tx_oe, tx_out}, 32'h2);
    $display("tx test ended");
  endtask

  // hang guard, well above the roughly 1200 cycles the tests take
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 6000) begin
      errors++;
      results();
    end
  end

  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    t_irq();
    t_rx();
    t_tx();
    results();
  end
endmodule // serial_port_flags_and_interrupts_bench

// ==== sfi_assertions.sv ====
`timescale 1ns/10ps
module sfi_checker (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rx_full_irq,
  input wire logic        tx_empty_irq,
  input wire logic        tx_done_irq,
  input wire logic        rx_error_irq,
  input wire logic        serial_irq,
  input wire logic [15:0] serial_irq_vector
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // control write at its completing edge; irq shows two edges later
  sequence ctrl_wr;
    psel && penable && pready && pwrite && paddr == sfi_pkg::ADDR_CTRL;
  endsequence
  irq_or_a:
    assert property (serial_irq == (rx_full_irq | tx_empty_irq | tx_done_irq | rx_error_irq))
    else $error("request line is not the or of the four");
  vector_a:
    assert property (serial_irq_vector == 16'h0024) else $error("vector moved");
  ready_wait_a:
    assert property ($rose(penable) && psel |-> !pready ##1 pready) else $error("wait state");
  ready_once_a:
    assert property (pready |=> !pready) else $error("ready held");
  err_ready_a:
    assert property (pslverr |-> pready) else $error("error without ready");
  txe_mask_a:
    assert property (ctrl_wr ##0 !pwdata[sfi_pkg::CTL_TIE] |=> ##1 !tx_empty_irq)
    else $error("masked empty request");
  rx_mask_a:
    assert property (ctrl_wr ##0 !pwdata[sfi_pkg::CTL_RIE] |=> ##1 !(rx_full_irq | rx_error_irq))
    else $error("masked rx request");
  done_idle_a:
    assert property (ctrl_wr ##0 pwdata[sfi_pkg::CTL_TX_DONE_IRQ_ENABLE] && !pwdata[sfi_pkg::CTL_TE]
      |=> ##2 tx_done_irq) else $error("idle done request missing");
endmodule // sfi_checker

bind sfi_serial_unit sfi_checker u_chk (.sys_clk(sys_clk), .rst(rst), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .rx_full_irq(rx_full_irq), .tx_empty_irq(tx_empty_irq),
  .tx_done_irq(tx_done_irq), .rx_error_irq(rx_error_irq), .serial_irq(serial_irq),
  .serial_irq_vector(serial_irq_vector));

// ==== sfi_pkg.sv ====
package sfi_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00; // serial_control_reg
  localparam logic [7:0] ADDR_STAT = 8'h04; // serial_status_reg
  localparam logic [7:0] ADDR_TXB  = 8'h08; // tx_buffer_reg
  localparam logic [7:0] ADDR_RXB  = 8'h0c; // rx_buffer_reg
  localparam logic [7:0] ADDR_BAUD = 8'h10; // 16x tick divisor
  localparam logic [7:0] ADDR_PORT = 8'h14; // port level / direction

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTL_SYNC = 0; // 1: clocked synchronous mode
  localparam int CTL_PAR  = 1; // 1: even parity bit (async)
  localparam int CTL_TX_DONE_IRQ_ENABLE = 2; // tx_done_irq_enable
  localparam int CTL_RE   = 4; // rx_enable
  localparam int CTL_TE   = 5; // tx_enable
  localparam int CTL_RIE  = 6; // rx_irq_enable
  localparam int CTL_TIE  = 7; // tx_empty_irq_enable
  localparam int ST_TDONE = 2;
  localparam int ST_PER   = 3;
  localparam int ST_FER   = 4;
  localparam int ST_OVR   = 5;
  localparam int ST_RXF   = 6;
  localparam int ST_TXE   = 7;
  localparam int PRT_LVL  = 0; // port_level_reg
  localparam int PRT_DIR  = 1; // port_direction_reg

  // ----------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] BAUD_RST  = 8'h00;
  localparam logic [1:0] PORT_RST  = 2'h0;
  localparam logic [3:0] PHASE_END = 4'hf; // 16 ticks per bit
  localparam logic [3:0] SAMPLE_AT = 4'h7; // 8th tick after edge
  localparam logic [2:0] LAST_BIT  = 3'h7; // 8 data bits
  localparam logic [15:0] IRQ_VECTOR = 16'h0024;

  // ----------------------------------------------------------------
  // frame state machines
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    SF_IDLE  = 5'b00001,
    SF_START = 5'b00010,
    SF_DATA  = 5'b00100,
    SF_PAR   = 5'b01000,
    SF_STOP  = 5'b10000
  } sfi_frame_t;

endpackage

// ==== sfi_serial_unit.sv ====
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
module sfi_serial_unit (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        serial_rx_pin,
  output logic             serial_tx_pin_out,
  output logic             serial_tx_pin_oe,
  output logic             serial_clk_out,
  output logic             rx_full_irq,
  output logic             tx_empty_irq,
  output logic             tx_done_irq,
  output logic             rx_error_irq,
  output logic             serial_irq,
  output logic [15:0]      serial_irq_vector
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0] serial_control_reg, next_serial_control_reg;
  logic [7:0] baud_div, next_baud_div;
  logic [1:0] port_reg, next_port_reg;
  logic [7:0] tx_buffer_reg, next_tx_buffer_reg;
  logic [7:0] rx_buffer_reg, next_rx_buffer_reg;
  logic       tx_empty_flag, next_tx_empty_flag;
  logic       tx_done_flag, next_tx_done_flag;
  logic       rx_full_flag, next_rx_full_flag;
  logic       overrun_flag, next_overrun_flag;
  logic       framing_error_flag, next_framing_error_flag;
  logic       parity_error_flag, next_parity_error_flag;
  logic [31:0] next_prdata;
  logic       next_pready, next_pslverr;
  logic [7:0] baud_cnt, next_baud_cnt;
  logic [3:0] bit_phase, next_bit_phase;
  sfi_pkg::sfi_frame_t tx_state, next_tx_state;
  logic [7:0] tx_shift_reg, next_tx_shift_reg;
  logic [2:0] tx_bits, next_tx_bits;
  logic       tx_line, next_tx_line;
  logic       tx_par, next_tx_par;
  logic       tx_load, tx_finish, tx_free;
  sfi_pkg::sfi_frame_t rx_state, next_rx_state;
  logic [7:0] rx_shift_reg, next_rx_shift_reg;
  logic [2:0] rx_bits, next_rx_bits;
  logic [3:0] rx_cnt, next_rx_cnt;
  logic       rx_par_bad, next_rx_par_bad;
  logic       rx_break, next_rx_break;
  logic       rx_last, next_rx_last;
  logic       rx_done, rx_fer, rx_sample;
  logic       rx_meta, rx_sync;
  logic       next_tx_pin_out, next_tx_pin_oe, next_clk_out;
  logic       tick, bit_end, any_err, sync_mode, start_ok;
  logic       acc, wr_ok, rd_ok, unmapped;

  assign sync_mode = serial_control_reg[sfi_pkg::CTL_SYNC];
  assign any_err   = overrun_flag | framing_error_flag | parity_error_flag;
  assign serial_irq_vector = sfi_pkg::IRQ_VECTOR;

  // ----------------------------------------------------------------
  // apb slave: one wait state so read data comes from a flop
  // ----------------------------------------------------------------
  assign acc      = psel & penable;
  assign wr_ok    = acc & pready & pwrite;
  assign rd_ok    = acc & pready & ~pwrite;
  assign unmapped = (paddr[1:0] != 2'h0) || (paddr > sfi_pkg::ADDR_PORT);

  // read mux and answer, captured in the first access cycle
  always_comb begin
    next_pready  = acc & ~pready;
    next_pslverr = acc & ~pready & unmapped;
    next_prdata  = prdata;
    if (acc & ~pready) begin
      next_prdata = 32'h0;
      case (paddr)
        sfi_pkg::ADDR_CTRL: next_prdata[7:0] = serial_control_reg;
        sfi_pkg::ADDR_STAT: next_prdata[7:0] = {tx_empty_flag, rx_full_flag,
          overrun_flag, framing_error_flag, parity_error_flag, tx_done_flag, 2'h0};
        sfi_pkg::ADDR_TXB:  next_prdata[7:0] = tx_buffer_reg;
        sfi_pkg::ADDR_RXB:  next_prdata[7:0] = rx_buffer_reg;
        sfi_pkg::ADDR_BAUD: next_prdata[7:0] = baud_div;
        sfi_pkg::ADDR_PORT: next_prdata[1:0] = port_reg;
        default:            next_prdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= next_pready;
      pslverr <= next_pslverr;
      prdata  <= next_prdata;
    end
  end

  // ----------------------------------------------------------------
  // control registers and buffers
  // ----------------------------------------------------------------
  always_comb begin
    next_serial_control_reg = serial_control_reg;
    next_baud_div           = baud_div;
    next_port_reg           = port_reg;
    next_tx_buffer_reg      = tx_buffer_reg;
    next_rx_buffer_reg      = rx_buffer_reg;
    if (wr_ok && paddr == sfi_pkg::ADDR_CTRL) next_serial_control_reg = pwdata[7:0];
    if (wr_ok && paddr == sfi_pkg::ADDR_BAUD) next_baud_div = pwdata[7:0];
    if (wr_ok && paddr == sfi_pkg::ADDR_PORT) next_port_reg = pwdata[1:0];
    if (wr_ok && paddr == sfi_pkg::ADDR_TXB) next_tx_buffer_reg = pwdata[7:0];
    // overrun leaves the old word in place
    if (rx_done && !rx_full_flag) next_rx_buffer_reg = next_rx_shift_reg;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      serial_control_reg <= sfi_pkg::CTRL_RST;
      baud_div           <= sfi_pkg::BAUD_RST;
      port_reg           <= sfi_pkg::PORT_RST;
      tx_buffer_reg      <= 8'h00;
      rx_buffer_reg      <= 8'h00;
    end else begin
      serial_control_reg <= next_serial_control_reg;
      baud_div           <= next_baud_div;
      port_reg           <= next_port_reg;
      tx_buffer_reg      <= next_tx_buffer_reg;
      rx_buffer_reg      <= next_rx_buffer_reg;
    end
  end

  // ----------------------------------------------------------------
  // status flags: hardware set wins over any clear in the same cycle
  // ----------------------------------------------------------------
  always_comb begin
    next_tx_empty_flag      = tx_empty_flag;
    next_tx_done_flag       = tx_done_flag;
    next_rx_full_flag       = rx_full_flag;
    next_overrun_flag       = overrun_flag;
    next_framing_error_flag = framing_error_flag;
    next_parity_error_flag  = parity_error_flag;
    if (wr_ok && paddr == sfi_pkg::ADDR_TXB) next_tx_empty_flag = 1'b0;
    if (tx_load) next_tx_empty_flag = 1'b1;
    // software clears by writing 0; rx_enable has no say here
    if (wr_ok && paddr == sfi_pkg::ADDR_STAT) begin
      if (!pwdata[sfi_pkg::ST_RXF]) next_rx_full_flag = 1'b0;
      if (!pwdata[sfi_pkg::ST_OVR]) next_overrun_flag = 1'b0;
      if (!pwdata[sfi_pkg::ST_FER]) next_framing_error_flag = 1'b0;
      if (!pwdata[sfi_pkg::ST_PER]) next_parity_error_flag = 1'b0;
    end
    if (rd_ok && paddr == sfi_pkg::ADDR_RXB) next_rx_full_flag = 1'b0;
    if (tx_load) next_tx_done_flag = 1'b0;
    if (tx_finish || !serial_control_reg[sfi_pkg::CTL_TE]) next_tx_done_flag = 1'b1;
    if (rx_done) begin
      if (rx_full_flag) next_overrun_flag = 1'b1;
      else next_rx_full_flag = 1'b1;
      if (rx_fer) next_framing_error_flag = 1'b1;
      if (rx_par_bad) next_parity_error_flag = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_empty_flag      <= 1'b1;
      tx_done_flag       <= 1'b1;
      rx_full_flag       <= 1'b0;
      overrun_flag       <= 1'b0;
      framing_error_flag <= 1'b0;
      parity_error_flag  <= 1'b0;
    end else begin
      tx_empty_flag      <= next_tx_empty_flag;
      tx_done_flag       <= next_tx_done_flag;
      rx_full_flag       <= next_rx_full_flag;
      overrun_flag       <= next_overrun_flag;
      framing_error_flag <= next_framing_error_flag;
      parity_error_flag  <= next_parity_error_flag;
    end
  end

  // ----------------------------------------------------------------
  // 16x tick divider and shared bit phase
  // ----------------------------------------------------------------
  assign tick    = (baud_cnt == baud_div);
  assign bit_end = tick && (bit_phase == sfi_pkg::PHASE_END);

  always_comb begin
    next_baud_cnt  = tick ? 8'h00 : baud_cnt + 8'h01;
    next_bit_phase = tick ? bit_phase + 4'h1 : bit_phase;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      baud_cnt  <= 8'h00;
      bit_phase <= 4'h0;
    end else begin
      baud_cnt  <= next_baud_cnt;
      bit_phase <= next_bit_phase;
    end
  end

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  // no handoff in a cycle that writes the buffer, so new data never
  // slips past a flag that was just set
  assign start_ok = !tx_empty_flag && !(wr_ok && paddr == sfi_pkg::ADDR_TXB)
                    && !(sync_mode && any_err);
  assign tx_free  = (tx_state == sfi_pkg::SF_IDLE) || (tx_state == sfi_pkg::SF_STOP) ||
                    (tx_state == sfi_pkg::SF_DATA && sync_mode &&
                     tx_bits == sfi_pkg::LAST_BIT);

  always_comb begin
    next_tx_state     = tx_state;
    next_tx_shift_reg = tx_shift_reg;
    next_tx_bits      = tx_bits;
    next_tx_line      = tx_line;
    next_tx_par       = tx_par;
    tx_load           = 1'b0;
    tx_finish         = 1'b0;
    if (bit_end) begin
      case (tx_state)
        sfi_pkg::SF_START: begin
          next_tx_state = sfi_pkg::SF_DATA;
          next_tx_line  = tx_shift_reg[0];
        end
        sfi_pkg::SF_DATA: begin
          next_tx_bits      = tx_bits + 3'h1;
          next_tx_shift_reg = {1'b1, tx_shift_reg[7:1]};
          next_tx_line      = tx_shift_reg[1];
          if (tx_bits == sfi_pkg::LAST_BIT) begin
            next_tx_state = serial_control_reg[sfi_pkg::CTL_PAR] ? sfi_pkg::SF_PAR
                                                                 : sfi_pkg::SF_STOP;
            next_tx_line  = serial_control_reg[sfi_pkg::CTL_PAR] ? tx_par : 1'b1;
          end
        end
        sfi_pkg::SF_PAR: begin
          next_tx_state = sfi_pkg::SF_STOP;
          next_tx_line  = 1'b1;
        end
        default: ;
      endcase
      // end of frame or idle: hand the buffer over or go to mark
      if (tx_free) begin
        if (serial_control_reg[sfi_pkg::CTL_TE] && start_ok) begin
          tx_load           = 1'b1;
          next_tx_shift_reg = tx_buffer_reg;
          next_tx_par       = ^tx_buffer_reg;
          next_tx_bits      = 3'h0;
          next_tx_state     = sync_mode ? sfi_pkg::SF_DATA : sfi_pkg::SF_START;
          next_tx_line      = sync_mode ? tx_buffer_reg[0] : 1'b0;
        end else begin
          tx_finish     = (tx_state != sfi_pkg::SF_IDLE);
          next_tx_state = sfi_pkg::SF_IDLE;
          next_tx_line  = 1'b1;
        end
      end
    end
    // disabling drops any frame in flight
    if (!serial_control_reg[sfi_pkg::CTL_TE]) begin
      next_tx_state = sfi_pkg::SF_IDLE;
      next_tx_line  = 1'b1;
      tx_load       = 1'b0;
      tx_finish     = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_state     <= sfi_pkg::SF_IDLE;
      tx_shift_reg <= 8'h00;
      tx_bits      <= 3'h0;
      tx_line      <= 1'b1;
      tx_par       <= 1'b0;
    end else begin
      tx_state     <= next_tx_state;
      tx_shift_reg <= next_tx_shift_reg;
      tx_bits      <= next_tx_bits;
      tx_line      <= next_tx_line;
      tx_par       <= next_tx_par;
    end
  end

  // ----------------------------------------------------------------
  // receive pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      rx_meta <= serial_rx_pin;
      rx_sync <= rx_meta;
    end
  end

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  // async samples 8 ticks after the edge; sync on the clock's rising edge
  assign rx_sample = tick && (sync_mode ? bit_phase == sfi_pkg::SAMPLE_AT
                                        : rx_cnt == sfi_pkg::SAMPLE_AT);

  always_comb begin
    next_rx_state     = rx_state;
    next_rx_shift_reg = rx_shift_reg;
    next_rx_bits      = rx_bits;
    next_rx_cnt       = tick ? rx_cnt + 4'h1 : rx_cnt;
    next_rx_par_bad   = rx_par_bad;
    next_rx_break     = rx_break & ~rx_sync;
    next_rx_last      = tick ? rx_sync : rx_last;
    rx_done           = 1'b0;
    rx_fer            = 1'b0;
    case (rx_state)
      sfi_pkg::SF_IDLE: begin
        next_rx_cnt     = 4'h0;
        next_rx_par_bad = 1'b0;
        // a held break restarts without a new falling edge once the error flags are clear, so the framing error recurs
        if (serial_control_reg[sfi_pkg::CTL_RE] && !any_err) begin
          if (sync_mode && bit_end) begin
            next_rx_state = sfi_pkg::SF_DATA;
            next_rx_bits  = 3'h0;
          end else if (!sync_mode && tick && !rx_sync && (rx_last || rx_break))
            next_rx_state = sfi_pkg::SF_START;
        end
      end
      sfi_pkg::SF_START: if (rx_sample) begin
        next_rx_state = rx_sync ? sfi_pkg::SF_IDLE : sfi_pkg::SF_DATA; // glitch rejected
        next_rx_bits  = 3'h0;
      end
      sfi_pkg::SF_DATA: if (rx_sample) begin
        next_rx_shift_reg = {rx_sync, rx_shift_reg[7:1]};
        next_rx_bits      = rx_bits + 3'h1;
        if (rx_bits == sfi_pkg::LAST_BIT) begin
          if (sync_mode) begin
            rx_done       = 1'b1;
            next_rx_state = sfi_pkg::SF_IDLE;
          end else
            next_rx_state = serial_control_reg[sfi_pkg::CTL_PAR] ? sfi_pkg::SF_PAR
                                                                 : sfi_pkg::SF_STOP;
        end
      end
      sfi_pkg::SF_PAR: if (rx_sample) begin
        next_rx_par_bad = (^rx_shift_reg) ^ rx_sync;
        next_rx_state   = sfi_pkg::SF_STOP;
      end
      sfi_pkg::SF_STOP: if (rx_sample) begin
        rx_done       = 1'b1;
        rx_fer        = !rx_sync;
        next_rx_break = !rx_sync;
        next_rx_state = sfi_pkg::SF_IDLE;
      end
      default: next_rx_state = sfi_pkg::SF_IDLE;
    endcase
    if (!serial_control_reg[sfi_pkg::CTL_RE]) begin
      next_rx_state = sfi_pkg::SF_IDLE;
      rx_done       = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_state     <= sfi_pkg::SF_IDLE;
      rx_shift_reg <= 8'h00;
      rx_bits      <= 3'h0;
      rx_cnt       <= 4'h0;
      rx_par_bad   <= 1'b0;
      rx_break     <= 1'b0;
      rx_last      <= 1'b1;
    end else begin
      rx_state     <= next_rx_state;
      rx_shift_reg <= next_rx_shift_reg;
      rx_bits      <= next_rx_bits;
      rx_cnt       <= next_rx_cnt;
      rx_par_bad   <= next_rx_par_bad;
      rx_break     <= next_rx_break;
      rx_last      <= next_rx_last;
    end
  end

  // ----------------------------------------------------------------
  // pins and interrupt requests
  // ----------------------------------------------------------------
  always_comb begin
    if (serial_control_reg[sfi_pkg::CTL_TE]) begin
      next_tx_pin_out = tx_line;
      next_tx_pin_oe  = 1'b1;
    end else begin
      next_tx_pin_out = port_reg[sfi_pkg::PRT_LVL];
      next_tx_pin_oe  = port_reg[sfi_pkg::PRT_DIR];
    end
    // sync clock: low in the first half of each bit, high otherwise
    next_clk_out = !(sync_mode && (tx_state == sfi_pkg::SF_DATA ||
                                   rx_state == sfi_pkg::SF_DATA))
                   || bit_phase[3];
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      serial_tx_pin_out <= 1'b1;
      serial_tx_pin_oe  <= 1'b0;
      serial_clk_out    <= 1'b1;
      tx_empty_irq      <= 1'b0;
      tx_done_irq       <= 1'b0;
      rx_full_irq       <= 1'b0;
      rx_error_irq      <= 1'b0;
      serial_irq        <= 1'b0;
    end else begin
      serial_tx_pin_out <= next_tx_pin_out;
      serial_tx_pin_oe  <= next_tx_pin_oe;
      serial_clk_out    <= next_clk_out;
      tx_empty_irq      <= tx_empty_flag & serial_control_reg[sfi_pkg::CTL_TIE];
      tx_done_irq       <= tx_done_flag & serial_control_reg[sfi_pkg::CTL_TX_DONE_IRQ_ENABLE];
      rx_full_irq       <= rx_full_flag & serial_control_reg[sfi_pkg::CTL_RIE];
      rx_error_irq      <= any_err & serial_control_reg[sfi_pkg::CTL_RIE];
      serial_irq        <= serial_control_reg[sfi_pkg::CTL_TIE] & tx_empty_flag
                         | serial_control_reg[sfi_pkg::CTL_TX_DONE_IRQ_ENABLE] & tx_done_flag
                         | serial_control_reg[sfi_pkg::CTL_RIE] & (rx_full_flag | any_err);
    end
  end

endmodule // sfi_serial_unit

// ==== sfi_station.sv ====
`timescale 1ns/10ps
module sfi_station (
  input wire logic sys_clk,
  output logic     line
);
  initial line = 1'b1;
  // one frame, 16 clocks a bit at divisor 0; stop level 0 makes a break
  task automatic send(input logic [7:0] b, input logic stp);
    logic [9:0] f;
    f = {stp, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge sys_clk);
      line <= f[i];
      repeat (15) @(posedge sys_clk);
    end
  endtask
  // back to mark, the line's idle level
  task mark;
    @(posedge sys_clk);
    line <= 1'b1;
  endtask
endmodule // sfi_station
